// File: src/accept_pkg.sv
// Shared constants, field layouts and carrier types of the page accept checker.
package accept_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Operation selection and widths
	localparam logic [31:0] ACCEPT_LEAF     = 32'h0000_0005;
	localparam int          ADDR_W          = 64;
	localparam int          INFO_W          = 512;
	localparam int          VA_BITS         = 48;
	localparam int          INFO_ALIGN_BITS = 6;
	localparam int          PAGE_ALIGN_BITS = 12;
	localparam logic [11:0] LIMIT_LOW_ONES  = 12'hfff;

	////////////////////////////////////////////////////////////////////////////////
	// Page type encodings
	localparam logic [7:0] REGULAR_PAGE_TYPE        = 8'h01;
	localparam logic [7:0] THREAD_CONTROL_PAGE_TYPE = 8'h02;
	localparam logic [7:0] TRIMMED_PAGE_TYPE        = 8'h04;
	localparam logic [7:0] SHADOW_STACK_FIRST_TYPE  = 8'h05;
	localparam logic [7:0] SHADOW_STACK_REST_TYPE   = 8'h06;

	////////////////////////////////////////////////////////////////////////////////
	// Flag field positions inside the security info block
	localparam int FLAG_R_POS        = 0;
	localparam int FLAG_W_POS        = 1;
	localparam int FLAG_X_POS        = 2;
	localparam int FLAG_PENDING_POS  = 3;
	localparam int FLAG_MODIFIED_POS = 4;
	localparam int FLAG_PR_POS       = 5;
	localparam int FLAG_PT_LSB       = 8;
	// Every bit outside this mask is reserved and must read zero
	localparam logic [INFO_W-1:0] FLAG_MASK = 512'hff3f;

	////////////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef logic [ADDR_W-1:0] addr_t;

	typedef struct packed {
		logic [7:0] pt;
		logic       permission_restricted_flag;
		logic       modified;
		logic       pending;
		logic       x;
		logic       w;
		logic       r;
	} flags_t;

	typedef struct packed {
		logic       valid;
		logic       r;
		logic       w;
		logic       x;
		logic       pending;
		logic       modified;
		logic       blocked;
		logic       permission_restricted_flag;
		logic [7:0] pt;
		addr_t      owner;
		addr_t      enclave_addr;
	} map_entry_t;

	typedef struct packed {
		logic [63:0] reserved;
		logic        debug_opt_in;
		logic [31:0] current_save_area_index;
		logic [31:0] save_area_count;
		addr_t       async_exit_pointer;
		logic [63:0] state;
		addr_t       prior_shadow_stack_pointer;
		logic [31:0] fs_limit;
		logic [31:0] gs_limit;
	} tcs_t;

	typedef struct packed {
		logic [31:0] leaf;
		addr_t       rbx;
		addr_t       rcx;
		logic        in_enclave;
		logic        mode64;
		logic        locked_operand;
	} request_t;

	typedef struct packed {
		addr_t range_base;
		addr_t range_end;
		addr_t active_enclave_control;
		logic  cap_ss_accept;
		logic  ss_supported;
		logic  wide_mode_attribute;
		logic  tracked;
	} env_t;

	typedef struct packed {
		logic              in_cache;
		logic              granted;
		map_entry_t        entry;
		logic [INFO_W-1:0] info;
		tcs_t              thread_control_structure;
	} answer_t;

	typedef struct packed {
		logic  gp;
		logic  pf;
		logic  flags_clear;
		logic  zf;
		addr_t fault_addr;
		addr_t rax;
	} result_t;

	typedef enum logic [2:0] {
		MK_INFO_MAP,
		MK_INFO_BLOCK,
		MK_DEST_MAP,
		MK_DEST_LOCK,
		MK_DEST_RECHECK,
		MK_TCS_READ,
		MK_DEST_CLEAR,
		MK_DEST_UNLOCK
	} mem_kind_t;

endpackage : accept_pkg

// File: src/accept_reset_sync.sv
// Two-stage release synchroniser for the asynchronous active-low reset.
`timescale 1ns/100ps
module accept_reset_sync (
	input  wire logic clock,
	input  wire logic nrst,
	output logic      rst_n_sync
);
	logic stage_q;

	// Assert at once, release only after two clean edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stage_q    <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			stage_q    <= 1'b1;
			rst_n_sync <= stage_q;
		end
	end
endmodule : accept_reset_sync

// File: src/addr_check.sv
// Alignment, linear range and canonical form checks of one operand address.
`timescale 1ns/100ps
module addr_check #(
	parameter int ALIGN_BITS = 6,
	parameter int VA_BITS    = 48
) (
	input  wire accept_pkg::addr_t addr,
	input  wire accept_pkg::addr_t range_base,
	input  wire accept_pkg::addr_t range_end,
	output logic                   misaligned,
	output logic                   out_of_range,
	output logic                   non_canonical
);
	import accept_pkg::*;

	assign misaligned    = |addr[ALIGN_BITS-1:0];
	// Range end is exclusive
	assign out_of_range  = (addr < range_base) || (addr >= range_end);
	assign non_canonical = !((&addr[ADDR_W-1:VA_BITS-1]) || !(|addr[ADDR_W-1:VA_BITS-1]));
endmodule : addr_check

// File: src/enclave_page_accept_check.sv
// Checking and execution sequencer of the page accept leaf.
// Function
// R1: Software selects the accept operation by loading leaf index 05H before issuing.
// R2: Security info address from RBX, destination page from RCX, error code to RAX.
// R3: Operation allowed only inside an enclave, else general protection fault.
// R4: Security info address not 64-byte aligned gives general protection fault.
// R5: Info address outside enclave range faults; not in page cache gives page fault.
// R6: Info page map entry must be valid, readable, clean, regular, owned, matching.
// R7: Copy 64 info bytes to scratch; nonzero reserved field gives protection fault.
// R8: Destination address not 4-kilobyte aligned gives general protection fault.
// R9: Destination outside range faults; not in page cache gives page fault.
// R10: Without capability bit only two type, pending, modified, restricted combinations pass.
// R11: With capability bit shadow-stack types with pending alone are also accepted.
// R12: Destination entry must be valid, unblocked, of allowed type, owned, else page fault.
// R13: Destination page taken exclusively; already in use gives protection fault.
// R14: After taking page, entry must still be valid and owned, else page fault.
// R15: Address or attribute mismatch sets ZF, mismatch code in RAX, common exit.
// R16: Threads not yet tracked out sets ZF, not-tracked code in RAX, common exit.
// R17: Thread-control request needs zero reserved, opt-in, pointer, state and index below count.
// R18: With shadow stacks, thread-control prior shadow-stack pointer must be zero.
// R19: Non-64-bit enclave needs low twelve limit bits all ones in both segments.
// R20: On success clear pending, modified and restricted bits, clear ZF, zero RAX.
// R21: Common exit clears carry, parity, adjust, overflow and sign flags.
// R22: In 64-bit mode non-canonical or locked memory operands give protection fault.
// R23: Checks run in listed order; the first failing one alone is reported. The code checks R22 right after R3.
`timescale 1ns/100ps
module enclave_page_accept_check #(
	parameter logic [63:0] ATTR_MISMATCH_CODE = 64'h0000_0000_0000_0001,
	parameter logic [63:0] NOT_TRACKED_CODE   = 64'h0000_0000_0000_0002
) (
	input  wire logic                  clock,
	input  wire logic                  nrst,
	input  wire logic                  start,
	input  wire accept_pkg::request_t  req,
	input  wire accept_pkg::env_t      env,
	output logic                       mem_valid,
	output accept_pkg::mem_kind_t      mem_kind,
	output accept_pkg::addr_t          mem_addr,
	input  wire logic                  mem_ready,
	input  wire accept_pkg::answer_t   ans,
	output logic                       busy,
	output logic                       done,
	output accept_pkg::result_t        res
);
	import accept_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CHK_INFO,
		ST_INFO_MAP,
		ST_INFO_BLK,
		ST_CHK_DEST,
		ST_DEST_MAP,
		ST_LOCK,
		ST_RECHECK,
		ST_TCS_RD,
		ST_CLEAR,
		ST_UNLOCK,
		ST_DONE
	} state_t;

	typedef struct packed {
		state_t  st;
		addr_t   rbx;
		addr_t   rcx;
		logic    in_enclave;
		logic    mode64;
		logic    locked_op;
		flags_t  flags;
		logic    lock_held;
		result_t res;
	} core_t;

	core_t s_q;
	core_t s_d;
	logic  rst_n;
	logic  rbx_mis;
	logic  rbx_oor;
	logic  rbx_nc;
	logic  rcx_mis;
	logic  rcx_oor;
	logic  rcx_nc;

	accept_reset_sync u_reset_sync (
		.clock      (clock),
		.nrst       (nrst),
		.rst_n_sync (rst_n)
	);

	addr_check #(
		.ALIGN_BITS (INFO_ALIGN_BITS),
		.VA_BITS    (VA_BITS)
	) u_info_addr (
		.addr          (s_q.rbx),
		.range_base    (env.range_base),
		.range_end     (env.range_end),
		.misaligned    (rbx_mis),
		.out_of_range  (rbx_oor),
		.non_canonical (rbx_nc)
	);

	addr_check #(
		.ALIGN_BITS (PAGE_ALIGN_BITS),
		.VA_BITS    (VA_BITS)
	) u_dest_addr (
		.addr          (s_q.rcx),
		.range_base    (env.range_base),
		.range_end     (env.range_end),
		.misaligned    (rcx_mis),
		.out_of_range  (rcx_oor),
		.non_canonical (rcx_nc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Check functions
	function automatic addr_t page_base(input addr_t a);
		page_base = {a[ADDR_W-1:PAGE_ALIGN_BITS], {PAGE_ALIGN_BITS{1'b0}}};
	endfunction : page_base

	function automatic logic combo_legal(input flags_t f, input logic cap);
		logic reg_ok;
		logic tcs_ok;
		logic ss_ok;
		reg_ok = (f.pt == REGULAR_PAGE_TYPE) && !f.modified &&
			(f.permission_restricted_flag || f.pending);
		tcs_ok = ((f.pt == THREAD_CONTROL_PAGE_TYPE) || (f.pt == TRIMMED_PAGE_TYPE)) &&
			!f.permission_restricted_flag && !f.pending && f.modified;
		ss_ok  = ((f.pt == SHADOW_STACK_FIRST_TYPE) || (f.pt == SHADOW_STACK_REST_TYPE)) &&
			f.pending && !f.modified && !f.permission_restricted_flag;
		combo_legal = reg_ok || tcs_ok || (cap && ss_ok); // R10 R11
	endfunction : combo_legal

	function automatic logic dest_type_ok(input logic [7:0] pt);
		dest_type_ok = (pt == REGULAR_PAGE_TYPE) || (pt == THREAD_CONTROL_PAGE_TYPE) ||
			(pt == TRIMMED_PAGE_TYPE) || (pt == SHADOW_STACK_FIRST_TYPE) ||
			(pt == SHADOW_STACK_REST_TYPE);
	endfunction : dest_type_ok

	function automatic logic attr_match(input map_entry_t e, input flags_t f, input addr_t a);
		attr_match = (e.enclave_addr == a) && (e.pending == f.pending) &&
			(e.modified == f.modified) && (e.r == f.r) && (e.w == f.w) &&
			(e.x == f.x) && (e.pt == f.pt);
	endfunction : attr_match

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			ST_IDLE: begin
				if (start && (req.leaf == ACCEPT_LEAF)) begin // R1
					s_d.rbx        = req.rbx; // R2
					s_d.rcx        = req.rcx; // R2
					s_d.in_enclave = req.in_enclave;
					s_d.mode64     = req.mode64;
					s_d.locked_op  = req.locked_operand;
					s_d.lock_held  = 1'b0;
					s_d.res        = '0;
					s_d.st         = ST_CHK_INFO;
				end
			end
			ST_CHK_INFO: begin
				// Checks are chained so only the earliest failure is reported
				if (!s_q.in_enclave) begin
					s_d.res.gp = 1'b1; // R3 R23
				end else if (s_q.locked_op || (s_q.mode64 && (rbx_nc || rcx_nc))) begin
					s_d.res.gp = 1'b1; // R22
				end else if (rbx_mis) begin
					s_d.res.gp = 1'b1; // R4
				end else if (rbx_oor) begin
					s_d.res.gp = 1'b1; // R5
				end else begin
					s_d.st = ST_INFO_MAP;
				end
			end
			ST_INFO_MAP: begin
				if (mem_ready) begin
					if (!ans.in_cache) begin
						s_d.res.pf         = 1'b1; // R5
						s_d.res.fault_addr = s_q.rbx;
					end else if (!ans.entry.valid || !ans.entry.r || ans.entry.pending ||
						ans.entry.modified || ans.entry.blocked ||
						(ans.entry.pt != REGULAR_PAGE_TYPE) ||
						(ans.entry.owner != env.active_enclave_control) ||
						(ans.entry.enclave_addr != page_base(s_q.rbx))) begin
						s_d.res.pf         = 1'b1; // R6
						s_d.res.fault_addr = s_q.rbx;
					end else begin
						s_d.st = ST_INFO_BLK;
					end
				end
			end
			ST_INFO_BLK: begin
				if (mem_ready) begin
					s_d.flags.r                          = ans.info[FLAG_R_POS]; // R7
					s_d.flags.w                          = ans.info[FLAG_W_POS];
					s_d.flags.x                          = ans.info[FLAG_X_POS];
					s_d.flags.pending                    = ans.info[FLAG_PENDING_POS];
					s_d.flags.modified                   = ans.info[FLAG_MODIFIED_POS];
					s_d.flags.permission_restricted_flag = ans.info[FLAG_PR_POS];
					s_d.flags.pt                         = ans.info[FLAG_PT_LSB +: 8];
					if (|(ans.info & ~FLAG_MASK)) begin
						s_d.res.gp = 1'b1; // R7
					end else begin
						s_d.st = ST_CHK_DEST;
					end
				end
			end
			ST_CHK_DEST: begin
				if (rcx_mis) begin
					s_d.res.gp = 1'b1; // R8
				end else if (rcx_oor) begin
					s_d.res.gp = 1'b1; // R9
				end else begin
					s_d.st = ST_DEST_MAP;
				end
			end
			ST_DEST_MAP: begin
				if (mem_ready) begin
					if (!ans.in_cache) begin
						s_d.res.pf         = 1'b1; // R9
						s_d.res.fault_addr = s_q.rcx;
					end else if (!combo_legal(s_q.flags, env.cap_ss_accept)) begin
						s_d.res.gp = 1'b1; // R10 R11
					end else if (!ans.entry.valid || ans.entry.blocked ||
						!dest_type_ok(ans.entry.pt) ||
						(ans.entry.owner != env.active_enclave_control)) begin
						s_d.res.pf         = 1'b1; // R12
						s_d.res.fault_addr = s_q.rcx;
					end else begin
						s_d.st = ST_LOCK;
					end
				end
			end
			ST_LOCK: begin
				if (mem_ready) begin
					if (!ans.granted) begin
						s_d.res.gp = 1'b1; // R13
					end else begin
						s_d.lock_held = 1'b1; // R13
						s_d.st        = ST_RECHECK;
					end
				end
			end
			ST_RECHECK: begin
				if (mem_ready) begin
					// The entry may have changed between the first look and the lock
					if (!ans.entry.valid || (ans.entry.owner != env.active_enclave_control)) begin
						s_d.res.pf         = 1'b1; // R14
						s_d.res.fault_addr = s_q.rcx;
					end else if (!attr_match(ans.entry, s_q.flags, s_q.rcx)) begin
						s_d.res.zf          = 1'b1; // R15
						s_d.res.rax         = ATTR_MISMATCH_CODE;
						s_d.res.flags_clear = 1'b1; // R21
						s_d.st              = ST_UNLOCK;
					end else if (!env.tracked) begin
						s_d.res.zf          = 1'b1; // R16
						s_d.res.rax         = NOT_TRACKED_CODE;
						s_d.res.flags_clear = 1'b1; // R21
						s_d.st              = ST_UNLOCK;
					end else if (s_q.flags.pt == THREAD_CONTROL_PAGE_TYPE) begin
						s_d.st = ST_TCS_RD;
					end else begin
						s_d.st = ST_CLEAR;
					end
				end
			end
			ST_TCS_RD: begin
				if (mem_ready) begin
					if ((|ans.thread_control_structure.reserved) || ans.thread_control_structure.debug_opt_in ||
						(ans.thread_control_structure.current_save_area_index >= ans.thread_control_structure.save_area_count) ||
						(|ans.thread_control_structure.async_exit_pointer) || (|ans.thread_control_structure.state)) begin
						s_d.res.gp = 1'b1; // R17
					end else if (env.ss_supported && (|ans.thread_control_structure.prior_shadow_stack_pointer)) begin
						s_d.res.gp = 1'b1; // R18
					end else if (!env.wide_mode_attribute &&
						((ans.thread_control_structure.fs_limit[11:0] != LIMIT_LOW_ONES) ||
						(ans.thread_control_structure.gs_limit[11:0] != LIMIT_LOW_ONES))) begin
						s_d.res.gp = 1'b1; // R19
					end else begin
						s_d.st = ST_CLEAR;
					end
				end
			end
			ST_CLEAR: begin
				if (mem_ready) begin
					s_d.res.zf          = 1'b0; // R20
					s_d.res.rax         = '0;
					s_d.res.flags_clear = 1'b1; // R21
					s_d.st              = ST_UNLOCK;
				end
			end
			ST_UNLOCK: begin
				if (mem_ready) begin
					s_d.lock_held = 1'b0;
					s_d.st        = ST_DONE;
				end
			end
			ST_DONE: begin
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		// A fresh fault ends the sequence, giving the page back if it was taken
		if ((s_d.res.gp || s_d.res.pf) && !(s_q.res.gp || s_q.res.pf)) begin
			s_d.st = s_q.lock_held ? ST_UNLOCK : ST_DONE; // R23
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access channel and outputs
	always_comb begin
		mem_valid = 1'b1;
		mem_kind  = MK_INFO_MAP;
		mem_addr  = s_q.rcx;
		case (s_q.st)
			ST_INFO_MAP: begin
				mem_addr = page_base(s_q.rbx);
			end
			ST_INFO_BLK: begin
				mem_kind = MK_INFO_BLOCK;
				mem_addr = s_q.rbx;
			end
			ST_DEST_MAP: begin
				mem_kind = MK_DEST_MAP;
			end
			ST_LOCK: begin
				mem_kind = MK_DEST_LOCK;
			end
			ST_RECHECK: begin
				mem_kind = MK_DEST_RECHECK;
			end
			ST_TCS_RD: begin
				mem_kind = MK_TCS_READ;
			end
			ST_CLEAR: begin
				mem_kind = MK_DEST_CLEAR; // R20
			end
			ST_UNLOCK: begin
				mem_kind = MK_DEST_UNLOCK;
			end
			default: begin
				mem_valid = 1'b0;
			end
		endcase
	end

	assign busy = (s_q.st != ST_IDLE);
	assign done = (s_q.st == ST_DONE);
	assign res  = s_q.res;
endmodule : enclave_page_accept_check

// File: tb/enclave_page_accept_check_sva.sv
// Port-level properties of the page accept sequencer.
`timescale 1ns/100ps
module enclave_page_accept_check_sva #(
	parameter logic [63:0] ATTR_MISMATCH_CODE = 64'h1,
	parameter logic [63:0] NOT_TRACKED_CODE   = 64'h2
) (
	input wire logic                  clock,
	input wire logic                  nrst,
	input wire logic                  start,
	input wire accept_pkg::request_t  req,
	input wire logic                  mem_valid,
	input wire accept_pkg::mem_kind_t mem_kind,
	input wire accept_pkg::addr_t     mem_addr,
	input wire logic                  mem_ready,
	input wire accept_pkg::answer_t   ans,
	input wire logic                  busy,
	input wire logic                  done,
	input wire accept_pkg::result_t   res
);
	import accept_pkg::*;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_take;
		start && !busy && req.leaf == ACCEPT_LEAF;
	endsequence
	sequence s_outside;
		s_take ##0 !req.in_enclave;
	endsequence
	sequence s_lock_won;
		mem_valid && mem_ready && mem_kind == MK_DEST_LOCK && ans.granted;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	property p_outside;
		s_outside |=> !mem_valid ##1 (done && res.gp && !res.pf && !mem_valid);
	endproperty
	property p_ignore;
		start && !busy && req.leaf != ACCEPT_LEAF |=> !busy;
	endproperty
	property p_take;
		s_take |=> busy && !done;
	endproperty
	property p_hold;
		mem_valid && !mem_ready |=> mem_valid && $stable(mem_kind) && $stable(mem_addr);
	endproperty
	property p_addr;
		mem_valid |-> mem_addr == ((mem_kind == MK_INFO_MAP) ? {req.rbx[63:12], 12'h000}
			: (mem_kind == MK_INFO_BLOCK) ? req.rbx : req.rcx);
	endproperty
	property p_order;
		mem_valid && mem_ready |=> !mem_valid || mem_kind > $past(mem_kind);
	endproperty
	property p_unlock;
		s_lock_won |-> ##[1:60] (mem_valid && mem_kind == MK_DEST_UNLOCK);
	endproperty
	property p_clear_ok;
		mem_valid && mem_ready && mem_kind == MK_DEST_CLEAR |->
			##[1:20] (done && !res.gp && !res.pf && !res.zf && res.rax == 64'h0);
	endproperty
	property p_zf;
		done && res.zf |-> res.flags_clear && !res.gp && !res.pf
			&& (res.rax == ATTR_MISMATCH_CODE || res.rax == NOT_TRACKED_CODE);
	endproperty
	property p_fault;
		done && (res.gp || res.pf) |-> !res.flags_clear && !(res.gp && res.pf);
	endproperty
	property p_pf_addr;
		done && res.pf |-> res.fault_addr == req.rbx || res.fault_addr == req.rcx;
	endproperty
	property p_done_pulse;
		done |=> !done && !busy;
	endproperty

	a_outside: assert property (p_outside) else $error("outside request not faulted");
	a_ignore: assert property (p_ignore) else $error("foreign leaf was taken");
	a_take: assert property (p_take) else $error("accept leaf not taken");
	a_hold: assert property (p_hold) else $error("access changed before ready");
	a_addr: assert property (p_addr) else $error("access address wrong");
	a_order: assert property (p_order) else $error("access order broken");
	a_unlock: assert property (p_unlock) else $error("page lock never released");
	a_clear_ok: assert property (p_clear_ok) else $error("clear without success");
	a_zf: assert property (p_zf) else $error("error return wrong");
	a_fault: assert property (p_fault) else $error("fault result wrong");
	a_pf_addr: assert property (p_pf_addr) else $error("page fault address wrong");
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
endmodule : enclave_page_accept_check_sva

bind enclave_page_accept_check enclave_page_accept_check_sva #(
	.ATTR_MISMATCH_CODE(ATTR_MISMATCH_CODE),
	.NOT_TRACKED_CODE  (NOT_TRACKED_CODE)
) u_sva (.clock(clock), .nrst(nrst), .start(start), .req(req), .mem_valid(mem_valid),
	.mem_kind(mem_kind), .mem_addr(mem_addr), .mem_ready(mem_ready), .ans(ans),
	.busy(busy), .done(done), .res(res));

// File: tb/enclave_page_accept_check_tb_top.sv
// Random self-checking bench of the page accept sequencer.
`timescale 1ns/100ps
module enclave_page_accept_check_tb_top;
	import accept_pkg::*;
	localparam logic [63:0] MIS_CODE = 64'h1;
	localparam logic [63:0] TRK_CODE = 64'h2;
	logic              clock = 1'b0;
	logic              nrst = 1'b0;
	logic              start = 1'b0;
	request_t          req = '0;
	env_t              env = '0;
	logic              mem_ready = 1'b0;
	answer_t           ans = '0;
	logic              mem_valid;
	mem_kind_t         mem_kind;
	addr_t             mem_addr;
	logic              busy;
	logic              done;
	result_t           res;
	int                fails = 0;
	int                compares = 0;
	logic [31:0]       seed = 32'hefcf;
	logic [1:0]        wait_q = 2'h0;
	request_t          rq;
	env_t              ev;
	map_entry_t        ie, de, re;
	logic [INFO_W-1:0] ib;
	tcs_t              tc;
	logic              ic_i, ic_d, gr;

	enclave_page_accept_check #(
		.ATTR_MISMATCH_CODE(MIS_CODE),
		.NOT_TRACKED_CODE  (TRK_CODE)
	) dut (.clock(clock), .nrst(nrst), .start(start), .req(req), .env(env),
		.mem_valid(mem_valid), .mem_kind(mem_kind), .mem_addr(mem_addr),
		.mem_ready(mem_ready), .ans(ans), .busy(busy), .done(done), .res(res));

	always #25 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	// Memory answers after 1 to 4 cycles
	always @(posedge clock) begin
		if (mem_ready)
			mem_ready <= 1'b0;
		else if (mem_valid && wait_q != 2'h0)
			wait_q <= wait_q - 2'h1;
		else if (mem_valid) begin
			mem_ready <= 1'b1;
			wait_q <= seed[1:0];
			ans <= '{in_cache: (mem_kind == MK_INFO_MAP) ? ic_i : ic_d, granted: gr,
				entry: (mem_kind == MK_INFO_MAP) ? ie : (mem_kind == MK_DEST_RECHECK) ? re : de,
				info: ib, thread_control_structure: tc};
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic in_rng(addr_t a);
		return a >= ev.range_base && a < ev.range_end;
	endfunction : in_rng

	////////////////////////////////////////////////////////////////////////////////
	function automatic result_t expect_res(request_t q, env_t e);
		flags_t  f;
		result_t r;
		logic    cmb;
		int      k;
		f = {ib[15:8], ib[5:0]};
		cmb = (f.pt == REGULAR_PAGE_TYPE && (f[5] || f[3]) && !f[4])
			|| (f.pt inside {THREAD_CONTROL_PAGE_TYPE, TRIMMED_PAGE_TYPE} && f[5:3] == 3'b010)
			|| (e.cap_ss_accept && f.pt inside {SHADOW_STACK_FIRST_TYPE, SHADOW_STACK_REST_TYPE}
			&& f[5:3] == 3'b001);
		if (!q.in_enclave || q.locked_operand || (q.mode64 && (q.rbx[63:47] != {17{q.rbx[47]}}
			|| q.rcx[63:47] != {17{q.rcx[47]}})) || q.rbx[5:0] != 6'h0 || !in_rng(q.rbx))
			k = 1;
		else if (!ic_i || !ie.valid || !ie.r || ie.pending || ie.modified || ie.blocked
			|| ie.pt != REGULAR_PAGE_TYPE || ie.owner != e.active_enclave_control
			|| ie.enclave_addr != {q.rbx[63:12], 12'h000})
			k = 2;
		else if ((ib & ~FLAG_MASK) != '0 || q.rcx[11:0] != 12'h0 || !in_rng(q.rcx))
			k = 1;
		else if (!ic_d)
			k = 3;
		else if (!cmb)
			k = 1;
		else if (!de.valid || de.blocked || !(de.pt inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h06})
			|| de.owner != e.active_enclave_control)
			k = 3;
		else if (!gr)
			k = 1;
		else if (!re.valid || re.owner != e.active_enclave_control)
			k = 3;
		else if (de.enclave_addr != q.rcx || {de.modified, de.pending, de.x, de.w, de.r, de.pt}
			!= {f[4:0], f.pt})
			k = 4;
		else if (!e.tracked)
			k = 5;
		else if (f.pt == THREAD_CONTROL_PAGE_TYPE && (|{tc.reserved, tc.debug_opt_in,
			tc.async_exit_pointer, tc.state} || tc.current_save_area_index >= tc.save_area_count
			|| (e.ss_supported && tc.prior_shadow_stack_pointer != '0) || (!e.wide_mode_attribute
			&& (tc.fs_limit[11:0] & tc.gs_limit[11:0]) != LIMIT_LOW_ONES)))
			k = 1;
		else
			k = 0;
		r = '0;
		r.gp = k == 1;
		r.pf = k == 2 || k == 3;
		r.fault_addr = (k == 2) ? q.rbx : q.rcx;
		r.zf = k == 4 || k == 5;
		r.flags_clear = k == 0 || r.zf;
		r.rax = (k == 4) ? MIS_CODE : (k == 5) ? TRK_CODE : 64'h0;
		return r;
	endfunction : expect_res

	////////////////////////////////////////////////////////////////////////////////
	// Baseline with random flags, legal unless a shadow-stack type meets a clear capability bit, then one corruption picked by c
	task automatic setup(input int c);
		logic [31:0] v;
		v = rnd();
		if (c == 21)
			v[5:4] = 2'h1;
		ev = '{64'h4000_0000, 64'h4010_0000, 64'h7_5000, v[8], v[9], v[10], 1'b1};
		rq = '{ACCEPT_LEAF, 64'h4000_1040, 64'h4000_3000, 1'b1, v[11], 1'b0};
		ib = '0;
		ib[15:8] = REGULAR_PAGE_TYPE;
		ib[5:0] = {v[12], 1'b0, !v[12] | v[13], v[2:0]};
		if (v[5:4] != 2'h0) begin
			ib[15:8] = (v[5:4] == 2'h1) ? THREAD_CONTROL_PAGE_TYPE : (v[5:4] == 2'h2) ?
				TRIMMED_PAGE_TYPE : v[6] ? SHADOW_STACK_FIRST_TYPE : SHADOW_STACK_REST_TYPE;
			ib[5:3] = (v[5:4] == 2'h3) ? 3'b001 : 3'b010;
		end
		ie = '{valid: 1'b1, r: 1'b1, pt: REGULAR_PAGE_TYPE, owner: 64'h7_5000,
			enclave_addr: 64'h4000_1000, default: '0};
		de = '{valid: 1'b1, r: ib[0], w: ib[1], x: ib[2], pending: ib[3], modified: ib[4],
			permission_restricted_flag: v[7], pt: ib[15:8], owner: 64'h7_5000,
			enclave_addr: rq.rcx, blocked: 1'b0};
		tc = '{save_area_count: 32'h2, current_save_area_index: {31'h0, v[14]},
			fs_limit: 32'hfff, gs_limit: 32'h1fff, default: '0};
		ic_i = 1'b1;
		ic_d = 1'b1;
		gr = 1'b1;
		case (c)
			1: rq.in_enclave = 1'b0;
			2: rq.locked_operand = 1'b1;
			3: rq.rcx[63] = 1'b1;
			4: rq.rbx[5:0] = v[21:16] | 6'h1;
			5: rq.rbx = ev.range_end;
			6: ic_i = 1'b0;
			7: ie.blocked = 1'b1;
			8: ie.enclave_addr = 64'h4000_2000;
			9: ib[16 + int'(v[24:16]) % 496] = 1'b1;
			10: rq.rcx[11:0] = {v[23:16], 4'h8};
			11: rq.rcx = ev.range_base - 64'h1000;
			12: ic_d = 1'b0;
			13: ib[5:0] = v[21:16];
			14: de.blocked = 1'b1;
			15: de.pt = 8'h03;
			16: gr = 1'b0;
			18: de.w = ~de.w;
			19: de.enclave_addr = 64'h4000_4000;
			20: ev.tracked = 1'b0;
			21: if (v[20])
				case (v[19:17])
					3'h0: tc.reserved = 64'h1;
					3'h1: tc.debug_opt_in = 1'b1;
					3'h2: tc.current_save_area_index = 32'h2;
					3'h3: tc.async_exit_pointer = 64'h1000;
					3'h4: tc.state = 64'h1;
					3'h5: tc.prior_shadow_stack_pointer = 64'h8;
					3'h6: tc.fs_limit = 32'h0;
					default: tc.gs_limit = 32'hffe;
				endcase
			default: ;
		endcase
		re = de;
		re.owner = (c == 17) ? 64'h0 : de.owner;
	endtask : setup

	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic run_one();
		result_t e;
		int      n;
		e = expect_res(rq, ev);
		n = 0;
		@(posedge clock);
		req <= rq;
		env <= ev;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (done !== 1'b1 && n < 300);
		chk("done", 64'h1, 64'(done));
		chk("gp", 64'(e.gp), 64'(res.gp));
		chk("pf", 64'(e.pf), 64'(res.pf));
		chk("zf", 64'(e.zf), 64'(res.zf));
		chk("flags_clear", 64'(e.flags_clear), 64'(res.flags_clear));
		if (!e.gp && !e.pf)
			chk("rax", e.rax, res.rax);
		if (e.pf)
			chk("fault_addr", e.fault_addr, res.fault_addr);
	endtask : run_one

	task automatic end_sim();
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		req <= '{leaf: 32'h7, default: '0};
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		@(negedge clock);
		chk("busy", 64'h0, 64'(busy));
		for (int i = 0; i < 322; i++) begin
			setup((i < 22) ? i : int'(rnd() % 32'd30));
			run_one();
		end
		end_sim();
	end

	// 322 operations of under 60 cycles each
	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		$display("[FAIL] watchdog expected finish seen hang");
		end_sim();
	end
endmodule : enclave_page_accept_check_tb_top
